/* design/flps_top.sv */
// Flash protection, security and command setup controller with APB registers
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module flps_top
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_flash_rd,
   output logic [17:0] o_flash_addr,
   input wire logic [15:0] i_flash_rdata,
   output logic o_array_start,
   output logic [7:0] o_array_code,
   input wire logic i_array_done,
   output logic o_read_block,
   output logic o_secure,
   output logic [2:0] o_pf_scenario,
   output logic o_ee_prot_en,
   output logic [17:0] o_ee_prot_last,
   input wire logic i_stop_req,
   output logic o_stop_ack,
   output logic o_irq
);
   flps_pkg::flps_state_t state;
   logic [2:0] cmd_index;
   logic ccf;
   logic err;
   logic key_fail;
   logic [1:0] key_cnt;
   logic [7:0] security_cfg;
   logic [2:0] pf_scen;
   logic ee_open;
   logic [4:0] ee_size;
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic [1:0] acc_cnt;
   logic done_pulse;
   logic unlock_pulse;
   logic acc_wr;
   logic launch;
   logic pf_ok;
   logic key_bad;
   logic [4:0] ee_capped;
   logic [7:0] cmd_code;
   logic [31:0] next_rdata;
   logic next_err_addr;
   flps_ccob_if ccob ();

   flps_ccob_mem u_mem
   (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .bus(ccob)
   );

   //----------------------------------------------------------------------
   // APB slave
   //----------------------------------------------------------------------
   // Writes act at the edge where the registered ready is seen
   assign acc_wr = i_psel && i_penable && o_pready && i_pwrite;
   assign launch = acc_wr && i_paddr == flps_pkg::FLPS_OFS_STATUS && i_pstrb[0]
                   && i_pwdata[flps_pkg::FLPS_ST_CCF] && ccf
                   && state == flps_pkg::FLPS_ST_IDLE; // see R5
   assign pf_ok = flps_pkg::FLPS_PF_TRANS[{pf_scen, i_pwdata[2:0]}]; // see R15
   assign cmd_code = ccob.rd_data[15:8];

   // Access counter paces the answer so array read data is ready
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         acc_cnt <= 2'h0;
      else if (i_psel && i_penable && !o_pready)
         acc_cnt <= acc_cnt + 2'h1;
      else
         acc_cnt <= 2'h0;
   end

   // Read mux and unmapped address decode
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      next_err_addr = 1'b0;
      unique case (i_paddr)
         flps_pkg::FLPS_OFS_INDEX: next_rdata = {29'h0, cmd_index};
         flps_pkg::FLPS_OFS_DATA: next_rdata = {16'h0, ccob.rd_data}; // see R2
         flps_pkg::FLPS_OFS_STATUS: next_rdata = {30'h0, err, ccf};
         flps_pkg::FLPS_OFS_SECURITY: next_rdata = {24'h0, security_cfg};
         flps_pkg::FLPS_OFS_PFPROT: next_rdata = {29'h0, pf_scen}; // see R13
         flps_pkg::FLPS_OFS_EEPROT: next_rdata = {24'h0, ee_open, 2'h0, ee_size};
         flps_pkg::FLPS_OFS_IRQ_STAT: next_rdata = {30'h0, irq_stat};
         flps_pkg::FLPS_OFS_IRQ_MASK: next_rdata = {30'h0, irq_mask};
         default: next_err_addr = 1'b1;
      endcase
   end

   // Ready, read data and error come from flops
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_pready <= 1'b0;
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end
      else
      begin
         o_pready <= i_psel && i_penable && !o_pready && acc_cnt == flps_pkg::FLPS_ACC_LAST;
         if (i_psel && i_penable && !o_pready && acc_cnt == flps_pkg::FLPS_ACC_LAST)
         begin
            o_prdata <= i_pwrite ? 32'h0000_0000 : next_rdata;
            o_pslverr <= next_err_addr;
         end
      end
   end

   //----------------------------------------------------------------------
   // Command object access
   //----------------------------------------------------------------------
   // Index and words are frozen while a command runs
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         cmd_index <= 3'h0;
      else if (acc_wr && i_paddr == flps_pkg::FLPS_OFS_INDEX && i_pstrb[0] && ccf)
         cmd_index <= i_pwdata[2:0]; // see R2
   end

   assign ccob.wr_en = acc_wr && i_paddr == flps_pkg::FLPS_OFS_DATA && ccf; // see R4
   assign ccob.wr_idx = cmd_index;
   assign ccob.wr_strb = i_pstrb[1:0]; // see R3
   assign ccob.wr_data = i_pwdata[15:0];
   // The sequencer steers the read port to the presented key words
   assign ccob.rd_idx = (state == flps_pkg::FLPS_ST_IDLE) ? cmd_index : {1'b0, key_cnt} + 3'h1;

   //----------------------------------------------------------------------
   // Protection registers
   //----------------------------------------------------------------------
   // Program flash scenario takes only allowed transitions
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         pf_scen <= flps_pkg::FLPS_PF_RESET;
      else if (acc_wr && i_paddr == flps_pkg::FLPS_OFS_PFPROT && i_pstrb[0] && pf_ok)
         pf_scen <= i_pwdata[2:0]; // see R13, R14
   end

   // EEPROM size grows only, open bit clears only
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ee_open <= 1'b1;
         ee_size <= flps_pkg::FLPS_EE_SIZE_RESET;
      end
      else if (acc_wr && i_paddr == flps_pkg::FLPS_OFS_EEPROT && i_pstrb[0])
      begin
         ee_open <= ee_open && i_pwdata[flps_pkg::FLPS_EE_OPEN_BIT]; // see R16
         if (i_pwdata[4:0] > ee_size)
            ee_size <= i_pwdata[4:0]; // see R16
      end
   end

   // Protected window end; open bit disables the window
   assign ee_capped = (ee_size > flps_pkg::FLPS_EE_SIZE_CAP) ? flps_pkg::FLPS_EE_SIZE_CAP
                      : ee_size;
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_ee_prot_en <= 1'b0;
         o_ee_prot_last <= 18'h00000;
         o_pf_scenario <= flps_pkg::FLPS_PF_RESET;
      end
      else
      begin
         o_ee_prot_en <= !ee_open; // see R16
         o_ee_prot_last <= flps_pkg::FLPS_EE_BASE + {8'h00, ee_capped + 5'h01, 5'h00}
                           - 18'h00001; // see R1
         o_pf_scenario <= pf_scen;
      end
   end

   //----------------------------------------------------------------------
   // Command sequencer
   //----------------------------------------------------------------------
   assign key_bad = ccob.rd_data != i_flash_rdata || ccob.rd_data == flps_pkg::FLPS_KEY_ZERO
                    || ccob.rd_data == flps_pkg::FLPS_KEY_ONES; // see R11

   // Loads security at reset, runs key check or hands off to the array
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state <= flps_pkg::FLPS_ST_LOAD;
         ccf <= 1'b0;
         err <= 1'b0;
         security_cfg <= flps_pkg::FLPS_SECURITY_RESET;
         key_cnt <= 2'h0;
         key_fail <= 1'b0;
         o_flash_rd <= 1'b0;
         o_flash_addr <= 18'h00000;
         o_array_start <= 1'b0;
         o_array_code <= 8'h00;
         o_read_block <= 1'b0;
         done_pulse <= 1'b0;
         unlock_pulse <= 1'b0;
      end
      else
      begin
         o_flash_rd <= 1'b0;
         o_array_start <= 1'b0;
         done_pulse <= 1'b0;
         unlock_pulse <= 1'b0;
         if (acc_wr && i_paddr == flps_pkg::FLPS_OFS_STATUS && i_pstrb[0]
             && i_pwdata[flps_pkg::FLPS_ST_ERR])
            err <= 1'b0;
         unique case (state)
            flps_pkg::FLPS_ST_LOAD:
            begin
               o_flash_rd <= 1'b1;
               o_flash_addr <= flps_pkg::FLPS_ADDR_SECURITY; // see R8
               state <= flps_pkg::FLPS_ST_LOADRD;
            end
            flps_pkg::FLPS_ST_LOADRD:
               state <= flps_pkg::FLPS_ST_LOADCAP;
            flps_pkg::FLPS_ST_LOADCAP:
            begin
               security_cfg <= i_flash_rdata[7:0]; // see R8, R9
               ccf <= 1'b1;
               state <= flps_pkg::FLPS_ST_IDLE;
            end
            flps_pkg::FLPS_ST_IDLE:
               if (launch)
               begin
                  ccf <= 1'b0; // see R5
                  key_cnt <= 2'h0;
                  key_fail <= 1'b0;
                  if (cmd_code != flps_pkg::FLPS_CMD_VERIFY_KEY)
                  begin
                     o_array_start <= 1'b1;
                     o_array_code <= cmd_code;
                     state <= flps_pkg::FLPS_ST_ARRAY;
                  end
                  else if (security_cfg[flps_pkg::FLPS_BDKEY_LSB +: 2] == flps_pkg::FLPS_BDKEY_ON)
                  begin
                     o_flash_rd <= 1'b1;
                     o_flash_addr <= flps_pkg::FLPS_ADDR_KEY0; // see R10
                     o_read_block <= 1'b1; // see R12
                     state <= flps_pkg::FLPS_ST_KEYRD;
                  end
                  else
                  begin
                     err <= 1'b1;
                     ccf <= 1'b1;
                     done_pulse <= 1'b1;
                  end
               end
            flps_pkg::FLPS_ST_KEYRD:
               state <= flps_pkg::FLPS_ST_KEYCMP;
            flps_pkg::FLPS_ST_KEYCMP:
               if (key_cnt == 2'h3)
               begin
                  if (!key_fail && !key_bad)
                  begin
                     security_cfg[flps_pkg::FLPS_STATE_LSB +: 2]
                        <= flps_pkg::FLPS_STATE_OPEN; // see R10
                     unlock_pulse <= 1'b1;
                  end
                  else
                     err <= 1'b1;
                  o_read_block <= 1'b0; // see R12
                  ccf <= 1'b1; // see R5
                  done_pulse <= 1'b1;
                  state <= flps_pkg::FLPS_ST_IDLE;
               end
               else
               begin
                  key_fail <= key_fail || key_bad; // see R11
                  key_cnt <= key_cnt + 2'h1;
                  o_flash_rd <= 1'b1;
                  o_flash_addr <= o_flash_addr + flps_pkg::FLPS_KEY_STEP;
                  state <= flps_pkg::FLPS_ST_KEYRD;
               end
            flps_pkg::FLPS_ST_ARRAY:
               if (i_array_done)
               begin
                  ccf <= 1'b1; // see R5
                  done_pulse <= 1'b1;
                  state <= flps_pkg::FLPS_ST_IDLE;
               end
            default:
               state <= flps_pkg::FLPS_ST_LOAD;
         endcase
      end
   end

   //----------------------------------------------------------------------
   // Interrupts, stop handshake, security output
   //----------------------------------------------------------------------
   // Sticky events, set wins over a write-one clear
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         irq_stat <= 2'h0;
         irq_mask <= 2'h0;
      end
      else
      begin
         if (acc_wr && i_paddr == flps_pkg::FLPS_OFS_IRQ_MASK && i_pstrb[0])
            irq_mask <= i_pwdata[1:0];
         irq_stat[flps_pkg::FLPS_IRQ_DONE] <= done_pulse || (irq_stat[flps_pkg::FLPS_IRQ_DONE]
            && !(acc_wr && i_paddr == flps_pkg::FLPS_OFS_IRQ_STAT && i_pstrb[0]
            && i_pwdata[flps_pkg::FLPS_IRQ_DONE]));
         irq_stat[flps_pkg::FLPS_IRQ_UNLOCK] <= unlock_pulse
            || (irq_stat[flps_pkg::FLPS_IRQ_UNLOCK]
            && !(acc_wr && i_paddr == flps_pkg::FLPS_OFS_IRQ_STAT && i_pstrb[0]
            && i_pwdata[flps_pkg::FLPS_IRQ_UNLOCK]));
      end
   end

   // Level interrupt also serves as the wake source from wait
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_irq <= 1'b0;
         o_stop_ack <= 1'b0;
         o_secure <= 1'b1;
      end
      else
      begin
         o_irq <= |(irq_stat & irq_mask); // see R6
         o_stop_ack <= i_stop_req && ccf && state == flps_pkg::FLPS_ST_IDLE; // see R7
         o_secure <= security_cfg[flps_pkg::FLPS_STATE_LSB +: 2] != flps_pkg::FLPS_STATE_OPEN;
      end
   end

   //----------------------------------------------------------------------
   // Assertions
   //----------------------------------------------------------------------
   property p_ee_cap;
      @(posedge i_ref_clk) disable iff (i_rst) (ee_size >= 5'h0F) |=> o_ee_prot_last == 18'h005FF;
   endproperty
   a_ee_cap: assert property (p_ee_cap) else $error("eeprom window not capped"); // see R1
   property p_pf_trans;
      @(posedge i_ref_clk) disable iff (i_rst)
         1'b1 |=> flps_pkg::FLPS_PF_TRANS[{$past(pf_scen), pf_scen}];
   endproperty
   a_pf_trans: assert property (p_pf_trans) else $error("illegal scenario change"); // see R15
   property p_pf_ignore;
      @(posedge i_ref_clk) disable iff (i_rst)
         (acc_wr && i_paddr == flps_pkg::FLPS_OFS_PFPROT && !pf_ok)
         |=> $stable(pf_scen) ##1 o_pf_scenario == pf_scen;
   endproperty
   a_pf_ignore: assert property (p_pf_ignore) else $error("bad protect write took"); // see R14
   property p_ee_grow;
      @(posedge i_ref_clk) disable iff (i_rst)
         1'b1 |=> ee_size >= $past(ee_size) && !(ee_open && !$past(ee_open));
   endproperty
   a_ee_grow: assert property (p_ee_grow) else $error("eeprom protection loosened"); // see R16
   property p_launch;
      @(posedge i_ref_clk) disable iff (i_rst)
         launch |=> !ccf && state != flps_pkg::FLPS_ST_IDLE || ccf && err;
   endproperty
   a_launch: assert property (p_launch) else $error("launch did not start"); // see R5
   property p_stop;
      @(posedge i_ref_clk) disable iff (i_rst) !ccf |=> !o_stop_ack;
   endproperty
   a_stop: assert property (p_stop) else $error("stop granted while busy"); // see R7
   property p_block;
      @(posedge i_ref_clk) disable iff (i_rst)
         state == flps_pkg::FLPS_ST_KEYCMP |-> o_read_block && !ccf;
   endproperty
   a_block: assert property (p_block) else $error("reads open during key check"); // see R12
   property p_seed;
      @(posedge i_ref_clk) disable iff (i_rst)
         state == flps_pkg::FLPS_ST_LOADCAP |=> security_cfg == $past(i_flash_rdata[7:0]) && ccf;
   endproperty
   a_seed: assert property (p_seed) else $error("security not loaded"); // see R8
   property p_irq;
      @(posedge i_ref_clk) disable iff (i_rst) done_pulse && irq_mask[0] |=> ##1 o_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("completion interrupt missing"); // see R6
   property p_badkey;
      @(posedge i_ref_clk) disable iff (i_rst)
         state == flps_pkg::FLPS_ST_KEYCMP && key_cnt == 2'h3 && key_bad |=> !unlock_pulse && err;
   endproperty
   a_badkey: assert property (p_badkey) else $error("bad key unlocked"); // see R11
   c_launch: cover property (@(posedge i_ref_clk) disable iff (i_rst) launch);
   c_unlock: cover property (@(posedge i_ref_clk) disable iff (i_rst) unlock_pulse);
   c_stop: cover property (@(posedge i_ref_clk) disable iff (i_rst)
      i_stop_req && !ccf ##[1:50] o_stop_ack);
endmodule

/* design/flps_pkg.sv */
// Constants, register map and types of the flash protection and security block
//----------------------------------------------------------------------
// How it works
//----------------------------------------------------------------------
// How it works
// R1: Size code gives protected bytes from base
// R2: Six command words picked by index
// R3: Command words take byte wide accesses
// R4: Software loads code and parameters first
// R5: Writing complete flag launches; set at end
// R6: Wait mode changes nothing; interrupt wakes
// R7: Stop is granted only when idle
// R8: Security byte loaded from flash at reset
// R9: New security byte acts after reset
// R10: Matching keys unsecure when keys enabled
// R11: Keys 0000 and FFFF never match
// R12: Array reads blocked during key check
// R13: Program protection only tightens, reads back
// R14: Illegal protection writes are ignored
// R15: Only listed scenario transitions allowed
// R16: EEPROM size grows only; open clears only
package flps_pkg;
   // Register byte offsets
   localparam logic [7:0] FLPS_OFS_INDEX = 8'h00;
   localparam logic [7:0] FLPS_OFS_DATA = 8'h04;
   localparam logic [7:0] FLPS_OFS_STATUS = 8'h08;
   localparam logic [7:0] FLPS_OFS_SECURITY = 8'h0C;
   localparam logic [7:0] FLPS_OFS_PFPROT = 8'h10;
   localparam logic [7:0] FLPS_OFS_EEPROT = 8'h14;
   localparam logic [7:0] FLPS_OFS_IRQ_STAT = 8'h18;
   localparam logic [7:0] FLPS_OFS_IRQ_MASK = 8'h1C;
   // Command object array
   localparam int FLPS_CCOB_WORDS = 6;
   localparam logic [2:0] FLPS_CCOB_LAST = 3'h5;
   localparam logic [7:0] FLPS_CMD_VERIFY_KEY = 8'h0C;
   // Security configuration layout
   localparam int FLPS_STATE_LSB = 0;
   localparam int FLPS_BDKEY_LSB = 6;
   localparam logic [1:0] FLPS_STATE_OPEN = 2'h2;
   localparam logic [1:0] FLPS_BDKEY_ON = 2'h2;
   localparam logic [7:0] FLPS_SECURITY_RESET = 8'hFF;
   // Flash configuration addresses
   localparam logic [17:0] FLPS_ADDR_SECURITY = 18'h3FF0F;
   localparam logic [17:0] FLPS_ADDR_KEY0 = 18'h3FF00;
   localparam logic [17:0] FLPS_KEY_STEP = 18'h00002;
   localparam logic [15:0] FLPS_KEY_ZERO = 16'h0000;
   localparam logic [15:0] FLPS_KEY_ONES = 16'hFFFF;
   // EEPROM protection
   localparam logic [17:0] FLPS_EE_BASE = 18'h00400;
   localparam logic [4:0] FLPS_EE_SIZE_CAP = 5'h0F;
   localparam int FLPS_EE_OPEN_BIT = 7;
   localparam logic [4:0] FLPS_EE_SIZE_RESET = 5'h00;
   // Program flash protection: row of 8 bits per from-scenario, bit = to-scenario
   localparam logic [63:0] FLPS_PF_TRANS = 64'hFF5A3C18080C0A0F;
   localparam logic [2:0] FLPS_PF_RESET = 3'h7;
   // Status and interrupt bit positions
   localparam int FLPS_ST_CCF = 0;
   localparam int FLPS_ST_ERR = 1;
   localparam int FLPS_IRQ_DONE = 0;
   localparam int FLPS_IRQ_UNLOCK = 1;
   // Bus answer delay in access cycles
   localparam logic [1:0] FLPS_ACC_LAST = 2'h1;

   typedef enum logic [2:0]
   {
      FLPS_ST_LOAD = 3'b000,
      FLPS_ST_LOADRD = 3'b001,
      FLPS_ST_LOADCAP = 3'b010,
      FLPS_ST_IDLE = 3'b011,
      FLPS_ST_KEYRD = 3'b100,
      FLPS_ST_KEYCMP = 3'b101,
      FLPS_ST_ARRAY = 3'b110
   } flps_state_t;
endpackage

/* design/flps_ccob_if.sv */
// Carrier between the controller and the command object memory
`timescale 1ns/1ps
interface flps_ccob_if;
   logic wr_en;
   logic [2:0] wr_idx;
   logic [1:0] wr_strb;
   logic [15:0] wr_data;
   logic [2:0] rd_idx;
   logic [15:0] rd_data;
   modport ctrl (output wr_en, output wr_idx, output wr_strb, output wr_data,
                 output rd_idx, input rd_data);
   modport mem (input wr_en, input wr_idx, input wr_strb, input wr_data,
                input rd_idx, output rd_data);
endinterface

/* design/flps_ccob_mem.sv */
// Command object array: six words, byte writes, registered read
`timescale 1ns/1ps
module flps_ccob_mem
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   flps_ccob_if.mem bus
);
   logic [15:0] word [flps_pkg::FLPS_CCOB_WORDS];

   //----------------------------------------------------------------------
   // Storage
   //----------------------------------------------------------------------
   // One word per entry, each byte lane written on its own
   for (genvar w = 0; w < flps_pkg::FLPS_CCOB_WORDS; w++)
   begin : g_word
      always_ff @(posedge i_ref_clk or posedge i_rst)
      begin
         if (i_rst)
            word[w] <= 16'h0000;
         else if (bus.wr_en && bus.wr_idx == 3'(w))
         begin
            if (bus.wr_strb[0]) word[w][7:0] <= bus.wr_data[7:0]; // see R3
            if (bus.wr_strb[1]) word[w][15:8] <= bus.wr_data[15:8]; // see R3
         end
      end
   end

   //----------------------------------------------------------------------
   // Read port
   //----------------------------------------------------------------------
   // Word picked by index; out of range reads zero
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         bus.rd_data <= 16'h0000;
      else if (bus.rd_idx <= flps_pkg::FLPS_CCOB_LAST)
         bus.rd_data <= word[bus.rd_idx]; // see R2
      else
         bus.rd_data <= 16'h0000;
   end
endmodule

/* tb/flps_flash_model.sv */
// Flash array model: security byte, backdoor keys and command engine
`timescale 1ns/1ps
module flps_flash_model
#(
   parameter logic [7:0] SECURITY_BYTE = 8'h80,
   parameter int DONE_DLY = 12
)
(
   input wire logic i_ref_clk,
   input wire logic i_flash_rd,
   input wire logic [17:0] i_flash_addr,
   output logic [15:0] o_flash_rdata,
   input wire logic i_array_start,
   output logic o_array_done
);
   int cnt = 0;
   logic [15:0] key [4] = '{16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0};
   initial o_flash_rdata = 16'h0000;
   initial o_array_done = 1'h0;
   // Data one cycle after a request, scrambled when nothing is asked
   always @(posedge i_ref_clk)
   begin
      if (i_flash_rd && i_flash_addr == flps_pkg::FLPS_ADDR_SECURITY)
         o_flash_rdata <= {8'hA5, SECURITY_BYTE};
      else if (i_flash_rd)
         o_flash_rdata <= key[i_flash_addr[2:1]];
      else
         o_flash_rdata <= ~o_flash_rdata;
   end
   // Array finishes a launched command after a fixed delay
   always @(posedge i_ref_clk)
   begin
      cnt <= i_array_start ? DONE_DLY : (cnt > 0 ? cnt - 1 : 0);
      o_array_done <= (cnt == 1);
   end
endmodule

/* tb/flash_protection_security_tb_top.sv */
// Self-checking bench: protection, command array, security and interrupts
`timescale 1ns/1ps
module flash_protection_security_tb_top;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, stop_req = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rdv;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready, pslverr, fl_rd, a_start, a_done, rd_blk, secure, ee_en, stop_ack, irq, errv;
   logic [17:0] fl_addr, ee_last;
   logic [15:0] fl_data;
   logic [7:0] a_code;
   logic [2:0] pf;
   logic [2:0] pfw [7] = '{3'h6, 3'h7, 3'h5, 3'h1, 3'h2, 3'h3, 3'h0};
   logic [2:0] pfe [7] = '{3'h6, 3'h6, 3'h6, 3'h1, 3'h1, 3'h3, 3'h3};
   int n_mismatch = 0;
   int num_checks = 0;
   flps_top dut (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_flash_rd(fl_rd),
      .o_flash_addr(fl_addr), .i_flash_rdata(fl_data), .o_array_start(a_start),
      .o_array_code(a_code), .i_array_done(a_done), .o_read_block(rd_blk),
      .o_secure(secure), .o_pf_scenario(pf), .o_ee_prot_en(ee_en),
      .o_ee_prot_last(ee_last), .i_stop_req(stop_req), .o_stop_ack(stop_ack), .o_irq(irq));
   flps_flash_model fm (.i_ref_clk(clk), .i_flash_rd(fl_rd), .i_flash_addr(fl_addr),
      .o_flash_rdata(fl_data), .i_array_start(a_start), .o_array_done(a_done));
   // Clock
   always #10 clk = ~clk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] s);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'h1;
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'h1);
      chk(pready, 32'h1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d, 4'hF);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0, 4'hF);
      chk(rdv, e);
   endtask
   // Load five command words, point the index back at the code word and launch
   task automatic run(input logic [15:0] w0, w1, w2, w3, w4);
      logic [15:0] w [5];
      w = '{w0, w1, w2, w3, w4};
      for (int i = 0; i < 5; i++)
      begin
         wr(flps_pkg::FLPS_OFS_INDEX, 32'(i));
         wr(flps_pkg::FLPS_OFS_DATA, {16'h0, w[i]});
      end
      wr(flps_pkg::FLPS_OFS_INDEX, 32'h0);
      wr(flps_pkg::FLPS_OFS_STATUS, 32'h1);
   endtask
   task automatic wait_done;
      int n;
      n = 0;
      do
      begin
         apb(1'h0, flps_pkg::FLPS_OFS_STATUS, 32'h0, 4'hF);
         n++;
      end
      while (rdv[0] !== 1'h1 && n < 50);
      chk(rdv[0], 32'h1);
   endtask
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      repeat (6000) @(posedge clk);
      n_mismatch++;
      finish_test;
   end
   // Test sequence
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      repeat (4) @(posedge clk);
      chk({secure, pf}, 32'hF);
      rdc(flps_pkg::FLPS_OFS_SECURITY, 32'h80);
      for (int i = 0; i < 7; i++)
      begin
         wr(flps_pkg::FLPS_OFS_PFPROT, {29'h0, pfw[i]});
         rdc(flps_pkg::FLPS_OFS_PFPROT, {29'h0, pfe[i]});
      end
      chk(pf, 32'h3);
      wr(flps_pkg::FLPS_OFS_EEPROT, 32'h03);
      rdc(flps_pkg::FLPS_OFS_EEPROT, 32'h03);
      chk({ee_en, ee_last}, {1'h1, 18'h0047F});
      wr(flps_pkg::FLPS_OFS_EEPROT, 32'h82);
      rdc(flps_pkg::FLPS_OFS_EEPROT, 32'h03);
      wr(flps_pkg::FLPS_OFS_EEPROT, 32'h1F);
      rdc(flps_pkg::FLPS_OFS_EEPROT, 32'h1F);
      chk({ee_en, ee_last}, {1'h1, 18'h005FF});
      wr(flps_pkg::FLPS_OFS_INDEX, 32'h5);
      wr(flps_pkg::FLPS_OFS_DATA, 32'hA5A5);
      apb(1'h1, flps_pkg::FLPS_OFS_DATA, 32'h3C00, 4'h2);
      rdc(flps_pkg::FLPS_OFS_DATA, 32'h3CA5);
      wr(flps_pkg::FLPS_OFS_INDEX, 32'h6);
      rdc(flps_pkg::FLPS_OFS_DATA, 32'h0);
      // Wrong key set first, then the stored one
      run(16'h0C00, 16'h1234, 16'h5678, 16'h9ABC, 16'hFFFF);
      @(posedge clk);
      chk(rd_blk, 32'h1);
      rdc(flps_pkg::FLPS_OFS_STATUS, 32'h0);
      wait_done;
      chk({secure, rdv[1]}, 32'h3);
      wr(flps_pkg::FLPS_OFS_STATUS, 32'h2);
      run(16'h0C00, 16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0);
      wait_done;
      chk({secure, rd_blk}, 32'h0);
      rdc(flps_pkg::FLPS_OFS_SECURITY, 32'h82);
      // Array command with stop request pending and done interrupt
      wr(flps_pkg::FLPS_OFS_IRQ_MASK, 32'h3);
      wr(flps_pkg::FLPS_OFS_IRQ_STAT, 32'h3);
      run(16'h2000, 16'h0, 16'h0, 16'h0, 16'h0);
      stop_req <= 1'h1;
      repeat (2) @(posedge clk);
      chk({stop_ack, a_code}, {23'h0, 1'h0, 8'h20});
      wait_done;
      @(posedge clk);
      chk(stop_ack, 32'h1);
      rdc(flps_pkg::FLPS_OFS_IRQ_STAT, 32'h1);
      chk(irq, 32'h1);
      wr(flps_pkg::FLPS_OFS_IRQ_STAT, 32'h1);
      rdc(flps_pkg::FLPS_OFS_IRQ_STAT, 32'h0);
      chk(irq, 32'h0);
      apb(1'h0, 8'h20, 32'h0, 4'hF);
      chk(errv, 32'h1);
      // Mid-run reset: unlock is dropped, security byte is read again
      rst <= 1'h1;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      repeat (4) @(posedge clk);
      chk({secure, pf}, 32'hF);
      rdc(flps_pkg::FLPS_OFS_SECURITY, 32'h80);
      finish_test;
   end
endmodule
